/* pkg/cci_pkg.sv */
// Shared constants for the configuration command interpreter
package cci_pkg;
  // Function codes
  localparam logic [7:0] CCI_FC_READ = 8'h03;
  localparam logic [7:0] CCI_FC_WRITE = 8'h06;
  // Register addresses
  localparam logic [15:0] CCI_DEFAULT_RELOAD_CMD = 16'h8010;
  localparam logic [15:0] CCI_LOCK_STATE_QUERY = 16'h8020;
  localparam logic [15:0] CCI_LOCK_STATE_SET = 16'h8030;
  localparam logic [15:0] CCI_PICKUP_LOCATION_SET = 16'h8060;
  localparam logic [15:0] CCI_PICKUP_LOCATION_QUERY = 16'h8070;
  localparam logic [15:0] CCI_SETPOINT_ORIGIN_SET = 16'h80A0;
  localparam logic [15:0] CCI_SETPOINT_ORIGIN_QUERY = 16'h80B0;
  // Parameter encodings
  localparam logic [15:0] CCI_RELOAD_SOFT = 16'h0001;
  localparam logic [15:0] CCI_RELOAD_HARD = 16'h0002;
  localparam logic [15:0] CCI_ORIGIN_LOCAL = 16'h0000;
  localparam logic [15:0] CCI_ORIGIN_FGEN = 16'h0001;
  localparam logic [15:0] CCI_ORIGIN_ANALOG = 16'h0002;
  localparam logic [15:0] CCI_ORIGIN_ANALOG_ALT = 16'h0003;
  // Reset values
  localparam logic CCI_LOCK_RESET = 1'b0;
  localparam logic CCI_PICKUP_RESET = 1'b0;
  localparam logic [1:0] CCI_ORIGIN_RESET = 2'h0;
  // Explicit message codes
  localparam logic [7:0] CCI_SVC_GET = 8'h0E;
  localparam logic [7:0] CCI_SVC_SET = 8'h10;
  localparam logic [7:0] CCI_SVC_REPLY = 8'h80;
  localparam logic [15:0] CCI_CLASS_VENDOR = 16'h00A2;
  localparam logic [7:0] CCI_ATTR_NAME = 8'h01;
  localparam logic [7:0] CCI_ATTR_ACCESS = 8'h04;
  localparam logic [7:0] CCI_ATTR_VALUE = 8'h05;
  // Instance numbers mapped onto the three settings
  localparam logic [15:0] CCI_INST_LOCK = 16'h0001;
  localparam logic [15:0] CCI_INST_PICKUP = 16'h0002;
  localparam logic [15:0] CCI_INST_ORIGIN = 16'h0003;
  // Access attribute codes
  localparam logic [15:0] CCI_ACCESS_RW = 16'h0003;
  // General status codes
  localparam logic [7:0] CCI_GS_OK = 8'h00;
  localparam logic [7:0] CCI_GS_BAD_SVC = 8'h08;
  localparam logic [7:0] CCI_GS_BAD_VALUE = 8'h09;
  localparam logic [7:0] CCI_GS_BAD_ATTR = 8'h14;
  localparam logic [7:0] CCI_GS_BAD_PATH = 8'h05;
  localparam logic [7:0] CCI_GS_NO_CONN = 8'h11;
  // Connection limits
  localparam int CCI_MAX_CONN = 6;
  localparam int CCI_MAX_MSG_BYTES = 1526;
  localparam int CCI_RPI_MIN_MS = 100;
  localparam int CCI_RPI_MAX_MS = 10000;
  // Sense pickup selection
  typedef enum logic {CCI_PICK_LOCAL, CCI_PICK_REMOTE} cci_pick_type;
endpackage

/* design/cci_conn_table.sv */
`timescale 1ns/10ps
// Class 3 connection slot table with registered lookup result
module cci_conn_table #(
  parameter int SLOTS = 6,
  parameter int IDW = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic open_req,
  input wire logic close_req,
  input wire logic [IDW-1:0] conn_id,
  output logic open_ok,
  output logic close_ok,
  output logic hit_q,
  output logic [3:0] used_q
);
  logic [SLOTS-1:0] valid_q; // Slot occupied
  logic [IDW-1:0] id_q [SLOTS]; // Slot owner id
  logic [SLOTS-1:0] match; // Id found per slot
  logic [SLOTS-1:0] free_one; // Lowest free slot
  logic [SLOTS-1:0] free_mask;
  // Per-slot match and free search
  assign free_mask = ~valid_q;
  assign free_one = free_mask & (~free_mask + 1'b1);
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign match[g] = valid_q[g] && (id_q[g] == conn_id);
      // Slot owner register
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          valid_q[g] <= 1'b0;
          id_q[g] <= '0;
        end else if (open_ok && free_one[g]) begin
          valid_q[g] <= 1'b1;
          id_q[g] <= conn_id;
        end else if (close_ok && match[g]) begin
          valid_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // A full table refuses the open; duplicate id also refused
  assign open_ok = open_req && (|free_mask) && !(|match);
  assign close_ok = close_req && !open_req && (|match);
  // Registered lookup and occupancy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_q <= 1'b0;
      used_q <= 4'h0;
    end else begin
      hit_q <= |match;
      used_q <= used_q + 4'(open_ok) - 4'(close_ok);
    end
  end
endmodule

/* design/cci_config_cmd.sv */
`timescale 1ns/10ps
// Configuration command interpreter: register commands and explicit messages
// Notes on behaviour
// - Write 0x8010: 1 soft, 2 hard restore
// - Lock flag written 0x8030, read 0x8020
// - Locked: only stop button passes through
// - Sense location: 0 local, 1 remote
// - Set-point origin stored, read back separately
// - Origin resets to local
// - Origin routes generator or analog set points
// - Only get and set single attribute
// - Attributes name, access, value per instance
// - Every request gets success or failure answer
// - Device is target only, never initiates
// - Up to six explicit connections
// - Messages never exceed maximum connection size
// - Values move least significant byte first
module cci_config_cmd
  import cci_pkg::*;
#(
  parameter int DW = 16,
  parameter int BTN = 8,
  parameter int STOP_BIT = 0
) (
  input wire logic CLK,
  input wire logic RESET_N,
  // Register command port
  input wire logic REG_VALID,
  input wire logic [7:0] REG_FUNC,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic REG_DONE,
  output logic REG_OK,
  output logic [15:0] REG_RDATA,
  // Explicit message port
  input wire logic MSG_VALID,
  input wire logic [15:0] MSG_CONN,
  input wire logic [7:0] MSG_SERVICE,
  input wire logic [15:0] MSG_CLASS,
  input wire logic [15:0] MSG_INSTANCE,
  input wire logic [7:0] MSG_ATTR,
  input wire logic [10:0] MSG_LEN,
  input wire logic [15:0] MSG_DATA,
  output logic MSG_DONE,
  output logic [7:0] MSG_REPLY_SVC,
  output logic [7:0] MSG_STATUS,
  output logic [15:0] MSG_RDATA,
  output logic [7:0] MSG_BYTE0,
  output logic [7:0] MSG_BYTE1,
  // Connection management from the transport
  input wire logic CONN_OPEN,
  input wire logic CONN_CLOSE,
  input wire logic [15:0] CONN_ID,
  output logic CONN_ACCEPT,
  output logic [3:0] CONN_COUNT,
  // Front panel
  input wire logic [BTN-1:0] BUTTONS,
  output logic [BTN-1:0] BUTTONS_OUT,
  // Restore strobes
  output logic SOFT_RESTORE,
  output logic HARD_RESTORE,
  // Sense voltages and measurement
  input wire logic [DW-1:0] VOLT_LOCAL,
  input wire logic [DW-1:0] VOLT_REMOTE,
  output logic [DW-1:0] VOLT_MEAS,
  // Set-point sources, set-point output and stored setting outputs
  input wire logic [DW-1:0] SP_LOCAL,
  input wire logic [DW-1:0] SP_FGEN,
  input wire logic [DW-1:0] SP_ANALOG,
  output logic [DW-1:0] SP_OUT,
  output logic LOCK_STATE,
  output logic PICKUP_REMOTE,
  output logic [1:0] ORIGIN_SEL
);
  // Stored settings
  logic lock_q, lock_d;
  cci_pick_type pick_q, pick_d;
  logic [1:0] origin_q, origin_d;
  // Button synchroniser stages
  logic [BTN-1:0] btn_s1_q, btn_s2_q;
  // Register answer registers
  logic reg_done_q, reg_ok_q;
  logic [15:0] reg_rdata_q;
  // Message answer registers
  logic msg_done_q;
  logic [7:0] msg_svc_q, msg_stat_q;
  logic [15:0] msg_rdata_q;
  // Registered outputs
  logic soft_q, hard_q;
  logic [DW-1:0] volt_q, sp_q;

  // Register port decode
  logic is_rd, is_wr;
  logic wr_reload, wr_lock, wr_pick, wr_origin;
  logic rd_lock, rd_pick, rd_origin, rd_hit;
  logic val_reload, val_bool, val_origin;
  logic [1:0] origin_wval;
  logic reg_good;
  logic [15:0] reg_rmux;
  assign is_rd = REG_VALID && (REG_FUNC == CCI_FC_READ);
  assign is_wr = REG_VALID && (REG_FUNC == CCI_FC_WRITE);
  assign wr_reload = is_wr && (REG_ADDR == CCI_DEFAULT_RELOAD_CMD);
  assign wr_lock = is_wr && (REG_ADDR == CCI_LOCK_STATE_SET);
  assign wr_pick = is_wr && (REG_ADDR == CCI_PICKUP_LOCATION_SET);
  assign wr_origin = is_wr && (REG_ADDR == CCI_SETPOINT_ORIGIN_SET);
  assign rd_lock = is_rd && (REG_ADDR == CCI_LOCK_STATE_QUERY);
  assign rd_pick = is_rd && (REG_ADDR == CCI_PICKUP_LOCATION_QUERY);
  assign rd_origin = is_rd && (REG_ADDR == CCI_SETPOINT_ORIGIN_QUERY);
  assign rd_hit = rd_lock || rd_pick || rd_origin;
  // Value range checks
  assign val_reload = (REG_WDATA == CCI_RELOAD_SOFT) ||
                      (REG_WDATA == CCI_RELOAD_HARD);
  assign val_bool = (REG_WDATA[15:1] == 15'h0000);
  // Both printed encodings of external analog are accepted
  assign val_origin = (REG_WDATA == CCI_ORIGIN_LOCAL) ||
                      (REG_WDATA == CCI_ORIGIN_FGEN) ||
                      (REG_WDATA == CCI_ORIGIN_ANALOG) ||
                      (REG_WDATA == CCI_ORIGIN_ANALOG_ALT);
  assign origin_wval = (REG_WDATA == CCI_ORIGIN_ANALOG_ALT) ?
                       CCI_ORIGIN_ANALOG[1:0] : REG_WDATA[1:0];
  assign reg_good = (wr_reload && val_reload) ||
                    ((wr_lock || wr_pick) && val_bool) ||
                    (wr_origin && val_origin) || rd_hit;
  // Query read mux
  assign reg_rmux = rd_lock ? {15'h0000, lock_q} :
                    rd_pick ? {15'h0000, pick_q} :
                    rd_origin ? {14'h0000, origin_q} : 16'h0000;

  // Explicit message decode
  logic svc_get, svc_set, svc_ok, class_ok, inst_ok, attr_ok;
  logic conn_hit, len_ok, msg_wr_val, msg_good;
  logic m_lock, m_pick, m_origin;
  logic [15:0] inst_value, attr_rmux;
  logic [7:0] msg_status;
  logic [1:0] msg_origin_val;
  assign svc_get = (MSG_SERVICE == CCI_SVC_GET);
  assign svc_set = (MSG_SERVICE == CCI_SVC_SET);
  assign svc_ok = svc_get || svc_set;
  assign class_ok = (MSG_CLASS == CCI_CLASS_VENDOR);
  assign m_lock = (MSG_INSTANCE == CCI_INST_LOCK);
  assign m_pick = (MSG_INSTANCE == CCI_INST_PICKUP);
  assign m_origin = (MSG_INSTANCE == CCI_INST_ORIGIN);
  assign inst_ok = m_lock || m_pick || m_origin;
  // Name and access are read-only; only value may be set
  assign attr_ok = (MSG_ATTR == CCI_ATTR_VALUE) ||
                   (svc_get && ((MSG_ATTR == CCI_ATTR_NAME) ||
                   (MSG_ATTR == CCI_ATTR_ACCESS)));
  assign len_ok = (32'(MSG_LEN) <= CCI_MAX_MSG_BYTES);
  assign msg_origin_val = (MSG_DATA == CCI_ORIGIN_ANALOG_ALT) ?
                          CCI_ORIGIN_ANALOG[1:0] : MSG_DATA[1:0];
  assign msg_wr_val = m_origin ?
                      (MSG_DATA[15:2] == 14'h0000 ||
                       MSG_DATA == CCI_ORIGIN_ANALOG_ALT) :
                      (MSG_DATA[15:1] == 15'h0000);
  assign inst_value = m_lock ? {15'h0000, lock_q} :
                      m_pick ? {15'h0000, pick_q} :
                      {14'h0000, origin_q};
  // Name attribute returns the instance number itself
  assign attr_rmux = (MSG_ATTR == CCI_ATTR_NAME) ? MSG_INSTANCE :
                     (MSG_ATTR == CCI_ATTR_ACCESS) ? CCI_ACCESS_RW :
                     inst_value;
  // Status priority: connection, size, service, path, attribute, value
  assign msg_status = !conn_hit ? CCI_GS_NO_CONN :
                      !len_ok ? CCI_GS_BAD_VALUE :
                      !svc_ok ? CCI_GS_BAD_SVC :
                      !(class_ok && inst_ok) ? CCI_GS_BAD_PATH :
                      !attr_ok ? CCI_GS_BAD_ATTR :
                      (svc_set && !msg_wr_val) ? CCI_GS_BAD_VALUE :
                      CCI_GS_OK;
  assign msg_good = MSG_VALID && (msg_status == CCI_GS_OK);

  // Connection table; the lookup for a message uses MSG_CONN
  logic tbl_open_ok, tbl_hit;
  logic [3:0] tbl_used;
  logic [15:0] tbl_id;
  assign tbl_id = (CONN_OPEN || CONN_CLOSE) ? CONN_ID : MSG_CONN;
  // Messages are only served on an open connection
  logic tbl_hit_now;
  assign conn_hit = !(CONN_OPEN || CONN_CLOSE) && tbl_hit_now;
  cci_conn_table #(
    .SLOTS(CCI_MAX_CONN),
    .IDW(16)
  ) u_conn (
    .clk(CLK),
    .reset_n(RESET_N),
    .open_req(CONN_OPEN),
    .close_req(CONN_CLOSE),
    .conn_id(tbl_id),
    .open_ok(tbl_open_ok),
    .close_ok(),
    .hit_q(tbl_hit),
    .used_q(tbl_used)
  );
  // Combinational match via a one-slot cache is avoided: use registered
  // hit of the previous cycle only when the id was presented then.
  logic [15:0] last_id_q;
  assign tbl_hit_now = tbl_hit && (last_id_q == MSG_CONN);

  // Next values of the stored settings
  always_comb begin
    lock_d = lock_q;
    pick_d = pick_q;
    origin_d = origin_q;
    if (wr_lock && val_bool) begin
      lock_d = REG_WDATA[0];
    end else if (MSG_VALID && svc_set && m_lock && msg_good) begin
      lock_d = MSG_DATA[0];
    end
    if (wr_pick && val_bool) begin
      pick_d = cci_pick_type'(REG_WDATA[0]);
    end else if (MSG_VALID && svc_set && m_pick && msg_good) begin
      pick_d = cci_pick_type'(MSG_DATA[0]);
    end
    if (wr_origin && val_origin) begin
      origin_d = origin_wval;
    end else if (MSG_VALID && svc_set && m_origin && msg_good) begin
      origin_d = msg_origin_val;
    end
  end

  // Settings storage; origin comes up local
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_q <= CCI_LOCK_RESET;
      pick_q <= CCI_PICK_LOCAL;
      origin_q <= CCI_ORIGIN_RESET;
    end else begin
      lock_q <= lock_d;
      pick_q <= pick_d;
      origin_q <= origin_d;
    end
  end

  // Register port answer, one cycle after the request
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reg_done_q <= 1'b0;
      reg_ok_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
      soft_q <= 1'b0;
      hard_q <= 1'b0;
    end else begin
      reg_done_q <= REG_VALID;
      reg_ok_q <= reg_good;
      reg_rdata_q <= reg_rmux;
      soft_q <= wr_reload && (REG_WDATA == CCI_RELOAD_SOFT);
      hard_q <= wr_reload && (REG_WDATA == CCI_RELOAD_HARD);
    end
  end

  // Message answer: every request is answered once; never self-started
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      msg_done_q <= 1'b0;
      msg_svc_q <= 8'h00;
      msg_stat_q <= CCI_GS_OK;
      msg_rdata_q <= 16'h0000;
      last_id_q <= 16'h0000;
    end else begin
      msg_done_q <= MSG_VALID;
      last_id_q <= tbl_id;
      if (MSG_VALID) begin
        msg_svc_q <= MSG_SERVICE | CCI_SVC_REPLY;
        msg_stat_q <= msg_status;
        msg_rdata_q <= (msg_good && svc_get) ? attr_rmux : 16'h0000;
      end
    end
  end

  // Button synchroniser, pins are asynchronous
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      btn_s1_q <= '0;
      btn_s2_q <= '0;
    end else begin
      btn_s1_q <= BUTTONS;
      btn_s2_q <= btn_s1_q;
    end
  end

  // Sense and set-point routing, registered to keep outputs glitch free
  logic [DW-1:0] volt_mux, sp_mux;
  assign volt_mux = (pick_q == CCI_PICK_REMOTE) ? VOLT_REMOTE :
                    VOLT_LOCAL;
  assign sp_mux = (origin_q == CCI_ORIGIN_FGEN[1:0]) ? SP_FGEN :
                  (origin_q == CCI_ORIGIN_ANALOG[1:0]) ? SP_ANALOG :
                  SP_LOCAL;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      volt_q <= '0;
      sp_q <= '0;
    end else begin
      volt_q <= volt_mux;
      sp_q <= sp_mux;
    end
  end

  // Locked panel keeps only the stop button alive
  genvar b;
  generate
    for (b = 0; b < BTN; b++) begin : g_btn
      if (b == STOP_BIT) begin : g_stop
        assign BUTTONS_OUT[b] = btn_s2_q[b];
      end else begin : g_other
        assign BUTTONS_OUT[b] = btn_s2_q[b] && !lock_q;
      end
    end
  endgenerate

  // Output assignments; value bytes go low byte first
  assign REG_DONE = reg_done_q;
  assign REG_OK = reg_ok_q;
  assign REG_RDATA = reg_rdata_q;
  assign MSG_DONE = msg_done_q;
  assign MSG_REPLY_SVC = msg_svc_q;
  assign MSG_STATUS = msg_stat_q;
  assign MSG_RDATA = msg_rdata_q;
  assign MSG_BYTE0 = msg_rdata_q[7:0];
  assign MSG_BYTE1 = msg_rdata_q[15:8];
  assign CONN_ACCEPT = tbl_open_ok;
  assign CONN_COUNT = tbl_used;
  assign SOFT_RESTORE = soft_q;
  assign HARD_RESTORE = hard_q;
  assign VOLT_MEAS = volt_q;
  assign SP_OUT = sp_q;
  assign LOCK_STATE = lock_q;
  assign PICKUP_REMOTE = pick_q;
  assign ORIGIN_SEL = origin_q;
endmodule

/* testbench/cci_config_cmd_checker.sv */
// Assertion checker watching the command interpreter ports
`timescale 1ns/10ps
module cci_config_cmd_checker
  import cci_pkg::*;
#(
  parameter int DW = 16,
  parameter int BTN = 8,
  parameter int STOP_BIT = 0
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic REG_VALID,
  input wire logic [7:0] REG_FUNC,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_DONE,
  input wire logic MSG_VALID,
  input wire logic [7:0] MSG_SERVICE,
  input wire logic [15:0] MSG_CLASS,
  input wire logic MSG_DONE,
  input wire logic [7:0] MSG_REPLY_SVC,
  input wire logic [7:0] MSG_STATUS,
  input wire logic CONN_OPEN,
  input wire logic CONN_ACCEPT,
  input wire logic [3:0] CONN_COUNT,
  input wire logic [BTN-1:0] BUTTONS_OUT,
  input wire logic SOFT_RESTORE,
  input wire logic HARD_RESTORE,
  input wire logic [DW-1:0] VOLT_REMOTE,
  input wire logic [DW-1:0] VOLT_MEAS,
  input wire logic [DW-1:0] SP_ANALOG,
  input wire logic [DW-1:0] SP_OUT,
  input wire logic LOCK_STATE,
  input wire logic PICKUP_REMOTE,
  input wire logic [1:0] ORIGIN_SEL
);
  // Stop button bit, the one that survives the lock
  localparam logic [BTN-1:0] STOP_MASK = BTN'(1) << STOP_BIT;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  a_reg_answer: assert property (REG_VALID |=> REG_DONE)
    else $error("register request got no answer");
  a_soft_cause: assert property (SOFT_RESTORE |-> $past(REG_VALID &&
    REG_FUNC == CCI_FC_WRITE && REG_ADDR == CCI_DEFAULT_RELOAD_CMD &&
    REG_WDATA == CCI_RELOAD_SOFT)) else $error("stray soft restore");
  a_hard_cause: assert property (HARD_RESTORE |-> $past(REG_VALID &&
    REG_FUNC == CCI_FC_WRITE && REG_ADDR == CCI_DEFAULT_RELOAD_CMD &&
    REG_WDATA == CCI_RELOAD_HARD)) else $error("stray hard restore");
  a_msg_answer: assert property (MSG_VALID |=> MSG_DONE &&
    MSG_REPLY_SVC == ($past(MSG_SERVICE) | CCI_SVC_REPLY))
    else $error("message reply missing or wrong service");
  a_svc_only: assert property (MSG_VALID && MSG_SERVICE != CCI_SVC_GET &&
    MSG_SERVICE != CCI_SVC_SET |=> MSG_STATUS != CCI_GS_OK)
    else $error("unsupported service accepted");
  a_class_only: assert property (MSG_VALID &&
    MSG_CLASS != CCI_CLASS_VENDOR |=> MSG_STATUS != CCI_GS_OK)
    else $error("foreign class accepted");
  a_lock_mask: assert property (LOCK_STATE && $past(LOCK_STATE, 2) |->
    (BUTTONS_OUT & ~STOP_MASK) == '0) else $error("button passed lock");
  a_conn_full: assert property (CONN_OPEN && CONN_COUNT == 4'h6
    |-> !CONN_ACCEPT) else $error("seventh connection accepted");
  a_conn_bound: assert property (CONN_COUNT <= 4'h6)
    else $error("connection count above six");
  a_sense_route: assert property (PICKUP_REMOTE && $past(PICKUP_REMOTE)
    |-> VOLT_MEAS == $past(VOLT_REMOTE)) else $error("wrong sense voltage");
  a_origin_route: assert property (ORIGIN_SEL == 2'h2 &&
    $past(ORIGIN_SEL) == 2'h2 |-> SP_OUT == $past(SP_ANALOG))
    else $error("analog set point not routed");
  a_origin_code: assert property (ORIGIN_SEL != 2'h3)
    else $error("origin selector holds unused code");
  c_soft: cover property (SOFT_RESTORE);
  c_full: cover property (CONN_OPEN && CONN_COUNT == 4'h6);
  c_msg_ok: cover property (MSG_DONE && MSG_STATUS == CCI_GS_OK);
endmodule

bind cci_config_cmd cci_config_cmd_checker #(.DW(DW), .BTN(BTN),
  .STOP_BIT(STOP_BIT)) u_chk (.*);

/* testbench/cci_originator.sv */
// Remote originator model: opens connections, sends explicit requests
`timescale 1ns/10ps
module cci_originator (
  input wire logic CLK,
  input wire logic CONN_ACCEPT,
  output logic MSG_VALID,
  output logic [15:0] MSG_CONN,
  output logic [7:0] MSG_SERVICE,
  output logic [15:0] MSG_CLASS,
  output logic [15:0] MSG_INSTANCE,
  output logic [7:0] MSG_ATTR,
  output logic [10:0] MSG_LEN,
  output logic [15:0] MSG_DATA,
  output logic CONN_OPEN,
  output logic CONN_CLOSE,
  output logic [15:0] CONN_ID
);
  // Interval for the connection, inside the supported span; the conn task never sends it
  localparam int RPI_MS = 1000;
  // Idle lines at time zero
  initial begin
    {MSG_VALID, CONN_OPEN, CONN_CLOSE} = 3'h0;
    {MSG_CONN, MSG_CLASS, MSG_INSTANCE, MSG_DATA, CONN_ID} = '0;
    {MSG_SERVICE, MSG_ATTR, MSG_LEN} = '0;
  end
  // One-cycle open or close; acceptance is seen in the same cycle
  task automatic conn(input logic op, input logic [15:0] id,
    output logic acc);
    @(posedge CLK);
    CONN_OPEN <= op;
    CONN_CLOSE <= !op;
    CONN_ID <= id;
    #1 acc = CONN_ACCEPT;
    @(posedge CLK);
    CONN_OPEN <= 1'b0;
    CONN_CLOSE <= 1'b0;
  endtask
  // Connection id leads the request by one cycle for the lookup
  task automatic req(input logic [15:0] id, input logic [7:0] svc,
    input logic [15:0] cls, input logic [15:0] inst, input logic [7:0] attr,
    input logic [10:0] len, input logic [15:0] d);
    @(posedge CLK);
    MSG_CONN <= id;
    {MSG_SERVICE, MSG_CLASS, MSG_INSTANCE, MSG_ATTR} <= {svc, cls, inst, attr};
    MSG_LEN <= len;
    MSG_DATA <= d;
    @(posedge CLK);
    MSG_VALID <= 1'b1;
    @(posedge CLK);
    MSG_VALID <= 1'b0;
    // Released lines must not keep showing the old value
    MSG_DATA <= ~d;
    MSG_CONN <= ~id;
  endtask
endmodule

/* testbench/tb_cci_config_cmd.sv */
// Self-checking bench for the configuration command interpreter
`timescale 1ns/10ps
module tb_cci_config_cmd
  import cci_pkg::*;
;
  logic CLK, RESET_N, REG_VALID, REG_DONE, REG_OK, MSG_VALID, MSG_DONE;
  logic [7:0] REG_FUNC, MSG_SERVICE, MSG_ATTR, MSG_REPLY_SVC, MSG_STATUS;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, MSG_CONN, MSG_CLASS;
  logic [15:0] MSG_INSTANCE, MSG_DATA, MSG_RDATA, CONN_ID, e;
  logic [10:0] MSG_LEN, mlen;
  logic [7:0] MSG_BYTE0, MSG_BYTE1, BUTTONS, BUTTONS_OUT;
  logic CONN_OPEN, CONN_CLOSE, CONN_ACCEPT, SOFT_RESTORE, HARD_RESTORE;
  logic [3:0] CONN_COUNT;
  logic [15:0] VOLT_LOCAL, VOLT_REMOTE, VOLT_MEAS, SP_LOCAL, SP_FGEN;
  logic [15:0] SP_ANALOG, SP_OUT, mcls;
  logic LOCK_STATE, PICKUP_REMOTE, acc;
  logic [1:0] ORIGIN_SEL;
  int fail_count = 0;
  int n_checks = 0;
  // Stop button placed off bit zero to catch a hard-wired mask
  cci_config_cmd #(.STOP_BIT(2)) dut (.*);
  // Far-side originator owns the message and connection lines
  cci_originator org (.*);
  // 25 MHz clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] x,
    input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One register command, answer checked one cycle later
  task automatic rq(input logic [7:0] fc, input logic [15:0] a,
    input logic [15:0] d, input logic ok, input logic [15:0] rd);
    @(posedge CLK);
    {REG_VALID, REG_FUNC, REG_ADDR, REG_WDATA} <= {1'b1, fc, a, d};
    @(posedge CLK);
    REG_VALID <= 1'b0;
    #1 chk("reg done", 16'h1, {15'h0, REG_DONE});
    chk("reg ok", {15'h0, ok}, {15'h0, REG_OK});
    chk("reg rdata", rd, REG_RDATA);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
    input logic ok);
    rq(CCI_FC_WRITE, a, d, ok, 16'h0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    rq(CCI_FC_READ, a, 16'h0, 1'b1, x);
  endtask
  // One explicit request through the originator, reply checked
  task automatic msg(input logic [15:0] id, input logic [7:0] svc,
    input logic [15:0] inst, input logic [7:0] attr, input logic [15:0] d,
    input logic [7:0] st, input logic [15:0] x);
    org.req(id, svc, mcls, inst, attr, mlen, d);
    #1 chk("msg done", 16'h1, {15'h0, MSG_DONE});
    chk("msg svc", {8'h0, svc | CCI_SVC_REPLY}, {8'h0, MSG_REPLY_SVC});
    chk("msg status", {8'h0, st}, {8'h0, MSG_STATUS});
    if (st === CCI_GS_OK && svc === CCI_SVC_GET) begin
      chk("msg rdata", x, MSG_RDATA);
      chk("msg bytes", {x[7:0], x[15:8]}, {MSG_BYTE0, MSG_BYTE1});
    end
  endtask
  // Counts, verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the fewer than 200 cycles the tests need
  initial begin
    repeat (5000) @(posedge CLK);
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {RESET_N, REG_VALID, REG_FUNC, REG_ADDR, REG_WDATA} = '0;
    {BUTTONS, VOLT_LOCAL, VOLT_REMOTE} = {8'h00, 16'h1111, 16'h2222};
    {SP_LOCAL, SP_FGEN, SP_ANALOG} = {16'hA001, 16'hA002, 16'hA003};
    mcls = CCI_CLASS_VENDOR;
    mlen = 11'h008;
    repeat (19) @(posedge CLK);
    #1 chk("origin at reset", 16'h0, {14'h0, ORIGIN_SEL});
    @(posedge CLK);
    RESET_N <= 1'b1;
    rd(CCI_SETPOINT_ORIGIN_QUERY, 16'h0);
    rd(CCI_LOCK_STATE_QUERY, 16'h0);
    wr(CCI_DEFAULT_RELOAD_CMD, CCI_RELOAD_SOFT, 1'b1);
    chk("soft", 16'h1, {15'h0, SOFT_RESTORE});
    wr(CCI_DEFAULT_RELOAD_CMD, CCI_RELOAD_HARD, 1'b1);
    chk("hard", 16'h1, {15'h0, HARD_RESTORE});
    wr(CCI_DEFAULT_RELOAD_CMD, 16'h0003, 1'b0);
    chk("no restore", 16'h0, {14'h0, SOFT_RESTORE, HARD_RESTORE});
    BUTTONS <= 8'hFF;
    wr(CCI_LOCK_STATE_SET, 16'h0001, 1'b1);
    rd(CCI_LOCK_STATE_QUERY, 16'h1);
    repeat (4) @(posedge CLK);
    #1 chk("locked buttons", 16'h04, {8'h0, BUTTONS_OUT});
    wr(CCI_LOCK_STATE_SET, 16'h0002, 1'b0);
    rd(CCI_LOCK_STATE_QUERY, 16'h1);
    wr(CCI_LOCK_STATE_SET, 16'h0000, 1'b1);
    repeat (4) @(posedge CLK);
    #1 chk("free buttons", 16'hFF, {8'h0, BUTTONS_OUT});
    rq(CCI_FC_READ, CCI_LOCK_STATE_SET, 16'h0, 1'b0, 16'h0);
    rq(CCI_FC_WRITE, CCI_LOCK_STATE_QUERY, 16'h1, 1'b0, 16'h0);
    rq(CCI_FC_READ, 16'h9000, 16'h0, 1'b0, 16'h0);
    rq(8'h10, CCI_LOCK_STATE_SET, 16'h1, 1'b0, 16'h0);
    wr(CCI_PICKUP_LOCATION_SET, 16'h0001, 1'b1);
    rd(CCI_PICKUP_LOCATION_QUERY, 16'h1);
    chk("remote volt", VOLT_REMOTE, VOLT_MEAS);
    wr(CCI_PICKUP_LOCATION_SET, 16'h0002, 1'b0);
    wr(CCI_PICKUP_LOCATION_SET, 16'h0000, 1'b1);
    rd(CCI_PICKUP_LOCATION_QUERY, 16'h0);
    chk("local volt", VOLT_LOCAL, VOLT_MEAS);
    // Every origin code, the spare analog code folding onto 2
    for (int i = 0; i < 4; i++) begin
      e = (i == 3) ? 16'h0002 : 16'(i);
      wr(CCI_SETPOINT_ORIGIN_SET, 16'(i), 1'b1);
      rd(CCI_SETPOINT_ORIGIN_QUERY, e);
      chk("set point", e == 0 ? SP_LOCAL : e == 1 ? SP_FGEN : SP_ANALOG,
        SP_OUT);
    end
    wr(CCI_SETPOINT_ORIGIN_SET, 16'h0004, 1'b0);
    rd(CCI_SETPOINT_ORIGIN_QUERY, 16'h2);
    // Fill the connection table, with a duplicate in the middle
    for (int i = 1; i < 8; i++) begin
      if (i == 6) begin
        org.conn(1'b1, 16'h3, acc);
        chk("dup open", 16'h0, {15'h0, acc});
      end
      org.conn(1'b1, 16'(i), acc);
      chk("open", {15'h0, i < 7}, {15'h0, acc});
    end
    #1 chk("count", 16'h6, {12'h0, CONN_COUNT});
    msg(16'h9, CCI_SVC_GET, CCI_INST_LOCK, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_NO_CONN, 16'h0);
    msg(16'h1, CCI_SVC_SET, CCI_INST_LOCK, CCI_ATTR_VALUE, 16'h1,
      CCI_GS_OK, 16'h0);
    msg(16'h2, CCI_SVC_GET, CCI_INST_LOCK, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_OK, 16'h1);
    msg(16'h2, CCI_SVC_GET, CCI_INST_ORIGIN, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_OK, 16'h2);
    msg(16'h3, CCI_SVC_GET, CCI_INST_PICKUP, CCI_ATTR_NAME, 16'h0,
      CCI_GS_OK, 16'h2);
    msg(16'h3, CCI_SVC_GET, CCI_INST_ORIGIN, CCI_ATTR_ACCESS, 16'h0,
      CCI_GS_OK, CCI_ACCESS_RW);
    msg(16'h4, 8'h01, CCI_INST_LOCK, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_BAD_SVC, 16'h0);
    msg(16'h4, CCI_SVC_GET, 16'h0009, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_BAD_PATH, 16'h0);
    msg(16'h5, CCI_SVC_GET, CCI_INST_LOCK, 8'h02, 16'h0,
      CCI_GS_BAD_ATTR, 16'h0);
    msg(16'h5, CCI_SVC_SET, CCI_INST_ORIGIN, CCI_ATTR_VALUE, 16'h7,
      CCI_GS_BAD_VALUE, 16'h0);
    mlen = 11'd1527;
    msg(16'h5, CCI_SVC_SET, CCI_INST_ORIGIN, CCI_ATTR_VALUE, 16'h1,
      CCI_GS_BAD_VALUE, 16'h0);
    mlen = 11'h008;
    mcls = 16'h00A3;
    msg(16'h6, CCI_SVC_GET, CCI_INST_LOCK, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_BAD_PATH, 16'h0);
    rd(CCI_SETPOINT_ORIGIN_QUERY, 16'h2);
    mcls = CCI_CLASS_VENDOR;
    org.conn(1'b0, 16'h1, acc);
    #1 chk("count after close", 16'h5, {12'h0, CONN_COUNT});
    msg(16'h1, CCI_SVC_GET, CCI_INST_LOCK, CCI_ATTR_VALUE, 16'h0,
      CCI_GS_NO_CONN, 16'h0);
    report_and_stop();
  end
endmodule
